// File: src/sw_cfg_pkg.sv
// Package of offsets, fields, resets and timing for switch config and status
package sw_cfg_pkg;
    localparam logic [11:0] BOOT_STRAP_STATUS_OFS   = 12'h004;
    localparam logic [11:0] UPSTREAM_SBR_DELAY_OFS  = 12'h08c;
    localparam logic [11:0] SWITCH_CONTROL_OFS      = 12'h000;
    localparam int          BCAST_MSG_DROP_BIT      = 19;
    localparam logic        BCAST_MSG_DROP_RST      = 1'h0;
    localparam logic [15:0] SBR_DELAY_US_RST        = 16'h0000;
    localparam int          CLK_MHZ                 = 100;
    localparam int          US_NS                   = 1000;
    localparam int          CLK_PERIOD_NS           = 1000 / CLK_MHZ;
    localparam int          TICK_CYCLES             = US_NS / CLK_PERIOD_NS;
    localparam int          SW_MODE_LSB             = 0;
    localparam int          GCLK_BIT                = 4;
    localparam int          SMADDR_LSB              = 12;
    localparam int          HOLD_BIT                = 16;
    localparam int          CLK_MODE_LSB            = 21;
    localparam int          MERGE_LSB               = 24;

    typedef struct packed {
        logic [3:0] switch_mode_strap;
        logic       global_clk_freq_strap;
        logic [3:0] slave_mgmt_addr_strap;
        logic       reset_hold_strap;
        logic [2:0] clock_mode_strap;
        logic       pair67_merge_strap;
        logic       pair45_merge_strap;
        logic       pair23_merge_strap;
        logic       pair01_merge_strap;
    } strap_t;

    typedef struct packed {
        logic        valid;
        logic        upstream;
        logic        vendor_bcast;
    } msg_info_t;
endpackage

// File: src/us_tick_gen.sv
// One-microsecond enable pulse generator
`timescale 1ns/1ps
module us_tick_gen #(
    parameter int CYCLES = 100
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_run,
    output logic      o_tick
);
    logic [15:0] cnt;
    wire         wrap = (cnt == 16'(CYCLES - 1));

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt    <= 16'h0000;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt    <= 16'h0000;
            o_tick <= 1'b0;
        end else begin
            cnt    <= wrap ? 16'h0000 : cnt + 16'h0001;
            o_tick <= wrap;
        end
    end
endmodule

// File: src/switch_boot_status_and_sbr_delay.sv
// Switch boot strap status, broadcast drop control and bus reset delay timer
`timescale 1ns/1ps
module switch_boot_status_and_sbr_delay (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire sw_cfg_pkg::strap_t    i_straps,
    input  wire logic                  i_hold_release,
    input  wire logic                  i_cfg_wr,
    input  wire logic                  i_cfg_rd,
    input  wire logic [11:0]           i_cfg_addr,
    input  wire logic [31:0]           i_cfg_wdata,
    input  wire sw_cfg_pkg::msg_info_t i_msg,
    input  wire logic                  i_sbr_trigger,
    output logic [31:0]                o_cfg_rdata,
    output logic                       o_cfg_rvalid,
    output logic                       o_msg_forward,
    output logic                       o_msg_credit_return,
    output logic                       o_msg_error,
    output logic                       o_sbr_start,
    output logic                       o_quasi_reset
);
    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    sw_cfg_pkg::strap_t straps;
    logic               captured;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            straps   <= '0;
            captured <= 1'b0;
        end else if (!captured) begin
            straps   <= i_straps;
            captured <= 1'b1;
        end
    end

    // Held, when the reset hold strap is set, until released over the management bus
    logic hold;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hold <= 1'b1;
        end else if (!captured) begin
            hold <= i_straps.reset_hold_strap;
        end else if (i_hold_release) begin
            hold <= 1'b0;
        end
    end
    wire quiet = !captured || hold;

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    logic        bcast_msg_drop;
    logic [15:0] sbr_delay_us;

    wire sel_ctl = (i_cfg_addr == sw_cfg_pkg::SWITCH_CONTROL_OFS);
    wire sel_sts = (i_cfg_addr == sw_cfg_pkg::BOOT_STRAP_STATUS_OFS);
    wire sel_dly = (i_cfg_addr == sw_cfg_pkg::UPSTREAM_SBR_DELAY_OFS);

    // Status word, one slice per strap field, reserved slices zero
    wire [31:0] sts_word;
    assign sts_word[sw_cfg_pkg::SW_MODE_LSB +: 4]   = straps.switch_mode_strap;
    assign sts_word[sw_cfg_pkg::GCLK_BIT]           = straps.global_clk_freq_strap;
    assign sts_word[sw_cfg_pkg::GCLK_BIT + 1 +: 7]  = 7'h00;
    assign sts_word[sw_cfg_pkg::SMADDR_LSB +: 4]    = straps.slave_mgmt_addr_strap;
    assign sts_word[sw_cfg_pkg::HOLD_BIT]           = straps.reset_hold_strap;
    assign sts_word[sw_cfg_pkg::HOLD_BIT + 1 +: 4]  = 4'h0;
    assign sts_word[sw_cfg_pkg::CLK_MODE_LSB +: 3]  = straps.clock_mode_strap;
    assign sts_word[sw_cfg_pkg::MERGE_LSB]          = straps.pair01_merge_strap;
    assign sts_word[sw_cfg_pkg::MERGE_LSB + 1]      = straps.pair23_merge_strap;
    assign sts_word[sw_cfg_pkg::MERGE_LSB + 2]      = straps.pair45_merge_strap;
    assign sts_word[sw_cfg_pkg::MERGE_LSB + 3]      = straps.pair67_merge_strap;
    assign sts_word[sw_cfg_pkg::MERGE_LSB + 4 +: 4] = 4'h0;

    wire [31:0] ctl_word = 32'(bcast_msg_drop) << sw_cfg_pkg::BCAST_MSG_DROP_BIT;
    wire [31:0] dly_word = {16'h0000, sbr_delay_us};
    wire [31:0] rd_word  = sel_sts ? sts_word :
                           sel_ctl ? ctl_word :
                           sel_dly ? dly_word : 32'h0000_0000;

    // Writes to the status word or to unmapped offsets fall through
    wire        wr_ctl     = i_cfg_wr && sel_ctl;
    wire        wr_dly     = i_cfg_wr && sel_dly;
    wire [31:0] next_rdata = i_cfg_rd ? rd_word : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bcast_msg_drop <= sw_cfg_pkg::BCAST_MSG_DROP_RST;
        end else if (wr_ctl) begin
            bcast_msg_drop <= i_cfg_wdata[sw_cfg_pkg::BCAST_MSG_DROP_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sbr_delay_us <= sw_cfg_pkg::SBR_DELAY_US_RST;
        end else if (wr_dly) begin
            sbr_delay_us <= i_cfg_wdata[15:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cfg_rdata  <= 32'h0000_0000;
            o_cfg_rvalid <= 1'b0;
        end else begin
            o_cfg_rvalid <= i_cfg_rd;
            o_cfg_rdata  <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Broadcast message filter
    // ------------------------------------------------------------
    // Gate on the registered hold so the gate and the hold output agree
    wire drop_msg     = bcast_msg_drop && i_msg.upstream && i_msg.vendor_bcast;
    wire take_msg     = i_msg.valid && !o_quasi_reset;
    wire next_forward = take_msg && !drop_msg;
    wire next_credit  = take_msg && drop_msg;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_msg_forward       <= 1'b0;
            o_msg_credit_return <= 1'b0;
            o_msg_error         <= 1'b0;
        end else begin
            o_msg_forward       <= next_forward;
            o_msg_credit_return <= next_credit;
            o_msg_error         <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Secondary bus reset delay
    // ------------------------------------------------------------
    logic [15:0] us_left;
    logic        waiting;
    logic        tick;

    us_tick_gen #(
        .CYCLES (sw_cfg_pkg::TICK_CYCLES)
    ) u_tick (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_run  (waiting),
        .o_tick (tick)
    );

    // One pending request at a time; triggers during a countdown are ignored
    wire        trig         = i_sbr_trigger && !o_quasi_reset && !waiting;
    wire        zero_delay   = (sbr_delay_us == 16'h0000);
    wire        step         = waiting && tick;
    wire        last_us      = step && (us_left == 16'h0001);
    wire [15:0] next_us_left = trig ? sbr_delay_us :
                               step ? us_left - 16'h0001 : us_left;
    wire        next_waiting = trig ? !zero_delay : (waiting && !last_us);
    wire        next_start   = trig ? zero_delay : last_us;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            us_left     <= 16'h0000;
            waiting     <= 1'b0;
            o_sbr_start <= 1'b0;
        end else begin
            us_left     <= next_us_left;
            waiting     <= next_waiting;
            o_sbr_start <= next_start;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_quasi_reset <= 1'b1;
        end else begin
            o_quasi_reset <= quiet;
        end
    end
endmodule

// File: sim/sw_cfg_monitor.sv
// Assertions on the switch status, broadcast drop and bus reset delay block
`timescale 1ns/1ps
module sw_cfg_monitor (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_cfg_wr,
    input  wire logic                  i_cfg_rd,
    input  wire logic [11:0]           i_cfg_addr,
    input  wire logic [31:0]           i_cfg_wdata,
    input  wire sw_cfg_pkg::msg_info_t i_msg,
    input  wire logic                  i_sbr_trigger,
    input  wire logic [31:0]           o_cfg_rdata,
    input  wire logic                  o_cfg_rvalid,
    input  wire logic                  o_msg_forward,
    input  wire logic                  o_msg_credit_return,
    input  wire logic                  o_msg_error,
    input  wire logic                  o_sbr_start,
    input  wire logic                  o_quasi_reset
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // ---------------------------------------------
    // Shadows of the written control fields and of the pending delay request
    // ---------------------------------------------
    logic        drop;
    logic [15:0] dly;
    logic        busy;
    wire         take = i_msg.valid && !o_quasi_reset;
    wire         hit  = i_msg.upstream && i_msg.vendor_bcast && drop;
    wire         idle = !busy || o_sbr_start;
    wire         trig = i_sbr_trigger && !o_quasi_reset && idle;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            drop <= 1'h0;
            dly  <= 16'h0000;
            busy <= 1'h0;
        end else begin
            if (i_cfg_wr && i_cfg_addr == 12'h000) drop <= i_cfg_wdata[19];
            if (i_cfg_wr && i_cfg_addr == 12'h08c) dly <= i_cfg_wdata[15:0];
            if (trig) busy <= 1'h1;
            else if (o_sbr_start) busy <= 1'h0;
        end
    end
    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    dly_read_a: assert property (i_cfg_rd && i_cfg_addr == 12'h08c |=>
        o_cfg_rvalid && o_cfg_rdata == {16'h0000, dly}) else $error("delay readback wrong");
    drop_read_a: assert property (i_cfg_rd && i_cfg_addr == 12'h000 |=>
        o_cfg_rvalid && o_cfg_rdata == {12'h000, drop, 19'h0}) else $error("drop bit wrong");
    drop_msg_a: assert property (take && hit |=>
        o_msg_credit_return && !o_msg_forward) else $error("broadcast not dropped");
    fwd_msg_a: assert property (take && !hit |=>
        o_msg_forward && !o_msg_credit_return) else $error("message not forwarded");
    no_error_a: assert property (!o_msg_error) else $error("error raised");
    held_quiet_a: assert property (o_quasi_reset |=>
        !o_msg_forward && !o_msg_credit_return && !o_sbr_start) else $error("active in hold");
    sbr_zero_a: assert property (trig && dly == 16'h0000 |=>
        o_sbr_start) else $error("zero delay start late");
    sbr_one_a: assert property (trig && dly == 16'h0001 |->
        ##1 !o_sbr_start ##101 o_sbr_start) else $error("one us delay wrong");
    start_cause_a: assert property (o_sbr_start |->
        busy) else $error("start without trigger");
    drop_c: cover property (take && hit);
    sbr_c: cover property (o_sbr_start);
    hold_c: cover property (o_quasi_reset && i_cfg_rd);
endmodule
bind switch_boot_status_and_sbr_delay sw_cfg_monitor mon (.i_clk, .i_nrst, .i_cfg_wr,
    .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata, .i_msg, .i_sbr_trigger, .o_cfg_rdata, .o_cfg_rvalid,
    .o_msg_forward, .o_msg_credit_return, .o_msg_error, .o_sbr_start, .o_quasi_reset);

// File: sim/switch_boot_status_and_sbr_delay_test.sv
// Testbench for the switch status and bus reset delay block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module switch_boot_status_and_sbr_delay_test;
    logic                  i_clk = 1'h0;
    logic                  i_nrst = 1'h0;
    sw_cfg_pkg::strap_t    i_straps = 17'h0b3ca;
    logic                  i_hold_release = 1'h0;
    logic                  i_cfg_wr = 1'h0;
    logic                  i_cfg_rd = 1'h0;
    logic [11:0]           i_cfg_addr = 12'h000;
    logic [31:0]           i_cfg_wdata = 32'h0;
    sw_cfg_pkg::msg_info_t i_msg = 3'h0;
    logic                  i_sbr_trigger = 1'h0;
    logic [31:0]           o_cfg_rdata;
    logic                  o_cfg_rvalid, o_msg_forward, o_msg_credit_return;
    logic                  o_msg_error, o_sbr_start, o_quasi_reset;
    int                    err_total = 0, n_tests = 0, cyc = 0;
    always #5 i_clk = ~i_clk;
    switch_boot_status_and_sbr_delay dut (.i_clk, .i_nrst, .i_straps, .i_hold_release,
        .i_cfg_wr, .i_cfg_rd, .i_cfg_addr, .i_cfg_wdata, .i_msg, .i_sbr_trigger, .o_cfg_rdata,
        .o_cfg_rvalid, .o_msg_forward, .o_msg_credit_return, .o_msg_error, .o_sbr_start,
        .o_quasi_reset);
    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task go; @(posedge i_clk); #1; endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        go; i_cfg_wr = 1'h1; i_cfg_addr = a; i_cfg_wdata = d; go; i_cfg_wr = 1'h0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string n);
        go; i_cfg_rd = 1'h1; i_cfg_addr = a; go; i_cfg_rd = 1'h0;
        `CHK("rvalid", 1'h1, o_cfg_rvalid)
        `CHK(n, e, o_cfg_rdata)
    endtask
    task msg(input logic u, input logic v, input logic f, input logic c);
        go; i_msg = {1'h1, u, v}; go; i_msg = 3'h0;
        `CHK("forward", f, o_msg_forward)
        `CHK("credit", c, o_msg_credit_return)
        `CHK("error", 1'h0, o_msg_error)
    endtask
    function logic [31:0] stat(sw_cfg_pkg::strap_t s);
        return {4'h0, s.pair67_merge_strap, s.pair45_merge_strap, s.pair23_merge_strap,
            s.pair01_merge_strap, s.clock_mode_strap, 4'h0, s.reset_hold_strap,
            s.slave_mgmt_addr_strap, 7'h00, s.global_clk_freq_strap, s.switch_mode_strap};
    endfunction
    task do_reset(input sw_cfg_pkg::strap_t s);
        i_nrst = 1'h0; i_straps = s; repeat (10) @(posedge i_clk); #1 i_nrst = 1'h1; go; go;
    endtask
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task t_held;
        do_reset(17'h0b3ca);
        `CHK("hold", 1'h1, o_quasi_reset)
        rd(12'h004, stat(i_straps), "status");
        wr(12'h004, 32'hffffffff);
        rd(12'h004, stat(i_straps), "status ro");
        rd(12'h08c, 32'h0, "delay rst");
        rd(12'h000, 32'h0, "ctrl rst");
        rd(12'h010, 32'h0, "unmapped");
        msg(1'h0, 1'h0, 1'h0, 1'h0);
        i_hold_release = 1'h1; go; i_hold_release = 1'h0; go; go;
        `CHK("hold off", 1'h0, o_quasi_reset)
    endtask
    task t_msg;
        msg(1'h1, 1'h1, 1'h1, 1'h0);
        wr(12'h000, 32'h00080000);
        rd(12'h000, 32'h00080000, "ctrl");
        msg(1'h1, 1'h1, 1'h0, 1'h1);
        msg(1'h0, 1'h1, 1'h1, 1'h0);
        msg(1'h1, 1'h0, 1'h1, 1'h0);
    endtask
    task t_sbr(input logic [15:0] n);
        int c, x;
        wr(12'h08c, {16'hffff, n});
        rd(12'h08c, {16'h0000, n}, "delay");
        go; i_sbr_trigger = 1'h1; go; i_sbr_trigger = 1'h0; c = 0; x = 0;
        while (o_sbr_start !== 1'h1 && c < 1000) begin
            go; c++; i_sbr_trigger = (c == 20);
        end
        i_sbr_trigger = 1'h0;
        `CHK("sbr wait", (n == 16'h0000) ? 0 : n * sw_cfg_pkg::TICK_CYCLES + 1, c)
        repeat (150) begin go; x += (o_sbr_start === 1'h1); end
        `CHK("extra start", 0, x)
    endtask
    task t_rst2;
        do_reset(17'h1c435);
        `CHK("no hold", 1'h0, o_quasi_reset)
        rd(12'h004, stat(i_straps), "status2");
        rd(12'h08c, 32'h0, "delay rst2");
        msg(1'h1, 1'h1, 1'h1, 1'h0);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin err_total++; test_done; end
    end
    initial begin
        t_held; t_msg;
        t_sbr(16'h0000); t_sbr(16'h0001); t_sbr(16'h0003);
        t_rst2;
        test_done;
    end
endmodule
